// [hw/vpa_pkg.sv]
package vpa_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LINE_START_LO = 8'h4c;
    localparam logic [7:0] IDX_LINE_COUNT_HI = 8'h4d;
    localparam logic [7:0] IDX_LINE_COUNT_LO = 8'h4e;
    localparam logic [7:0] IDX_MEASURE_CFG = 8'h4f;
    localparam logic [7:0] IDX_PHASE_CMD = 8'h50;
    localparam logic [7:0] IDX_PHASE_STATUS = 8'h51;
    localparam logic [7:0] IDX_VLINE_MASK = 8'h52;
    localparam logic [7:0] IDX_PIX_MASK_AFTER = 8'h53;
    localparam logic [7:0] IDX_PIX_MASK_BEFORE = 8'h54;
    localparam logic [7:0] IDX_CMD_OPTIONS = 8'h55;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h5b;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h5c;

    // reset values
    localparam logic [7:0] RST_LINE_START_LO = 8'h26;
    localparam logic [3:0] RST_LINE_COUNT_HI = 4'h4;
    localparam logic [7:0] RST_LINE_COUNT_LO = 8'h00;
    localparam logic [1:0] RST_MEASURE_CFG = 2'h0;
    localparam logic [6:0] RST_VLINE_MASK = 7'h01;
    localparam logic [7:0] RST_PIX_MASK_AFTER = 8'h01;
    localparam logic [7:0] RST_PIX_MASK_BEFORE = 8'h01;
    localparam logic [7:0] RST_CMD_OPTIONS = 8'h20;

    // field positions
    localparam int MC_VUNITS_BIT = 0;
    localparam int MC_LINECNT_BIT = 1;
    localparam int STATUS_BUSY_BIT = 7;
    localparam int VM_BEFORE_LSB = 0;
    localparam int VM_AFTER_LSB = 4;
    localparam int OPT_BLUE_OFF = 0;
    localparam int OPT_RED_OFF = 2;
    localparam int OPT_SEARCH_WORST = 3;
    localparam int OPT_STEP_SLOW = 4;
    localparam int OPT_UPDATE_ON_VSYNC = 5;
    localparam int OPT_ENGINE_CLEAR = 6;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_BADCMD_BIT = 1;

    // command codes
    localparam logic [2:0] CMD_APPLY_PHASE = 3'h3;
    localparam logic [2:0] CMD_APPLY_WINDOW = 3'h4;

    // timing counts
    localparam logic [6:0] STEP_VSYNCS_FAST = 7'h1c;
    localparam logic [6:0] STEP_VSYNCS_SLOW = 7'h40;
    localparam logic [8:0] XTAL_UNIT_LAST = 9'h1ff;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STEP = 2'b01,
        ST_WAITV = 2'b11,
        ST_DONE = 2'b10
    } vpa_state_e;
endpackage : vpa_pkg

// [hw/vpa_phase_adjust_regs.sv]
// How it works
// - line start low byte resets to 0x26
// - 12-bit visible line count, resets 0x400
// - vertical units: lines or 512 crystal clocks
// - line count method: integer or timed
// - command register write launches low three bits
// - 011 sets phase, 100 sets window
// - status bit 7 shows engine busy
// - lines masked before vsync edge, table lookup
// - lines masked after vsync edge, table lookup
// - mask 2N pixels after hsync edge
// - mask 2N pixels before hsync edge
// - option bits 0..2 drop blue, green, red
// - option bit 3 seeks worst phase
// - option bit 4: 28 or 64 vsync steps
// - option bit 5 defers phase to vsync
// - option bit 6 holds engine in reset
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vpa_phase_adjust_regs (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic HSYNC_IN,
    input wire logic VSYNC_IN,
    input wire logic PIXEL_EN,
    output logic IRQ,
    output logic PHASE_APPLY,
    output logic WINDOW_APPLY,
    output logic SEARCH_WORST,
    output logic [2:0] CHAN_MEASURE_EN,
    output logic COLLECT_EN,
    output logic VERT_TICK,
    output logic LINECOUNT_TIMED,
    output logic [7:0] LINE_START_LOW,
    output logic [11:0] LINE_COUNT
);
    function automatic logic [3:0] lines_before(input logic [2:0] code);
        case (code)
            3'h0: lines_before = 4'h0;
            3'h1: lines_before = 4'h1;
            3'h2: lines_before = 4'h2;
            3'h3: lines_before = 4'h4;
            3'h4: lines_before = 4'h6;
            3'h5: lines_before = 4'h8;
            3'h6: lines_before = 4'ha;
            default: lines_before = 4'hc;
        endcase
    endfunction : lines_before

    function automatic logic [5:0] lines_after(input logic [2:0] code);
        case (code)
            3'h0: lines_after = 6'h05;
            3'h1: lines_after = 6'h12;
            3'h2: lines_after = 6'h13;
            3'h3: lines_after = 6'h14;
            3'h4: lines_after = 6'h16;
            3'h5: lines_after = 6'h19;
            3'h6: lines_after = 6'h29;
            default: lines_after = 6'h2c;
        endcase
    endfunction : lines_after

    // registers
    logic [7:0] line_start_ff;
    logic [3:0] line_cnt_hi_ff;
    logic [7:0] line_cnt_lo_ff;
    logic [1:0] meas_cfg_ff;
    logic [6:0] vmask_ff;
    logic [7:0] hmask_after_ff;
    logic [7:0] hmask_before_ff;
    logic [7:0] opt_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;

    // bus state
    logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
    logic [7:0] aw_idx_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    // sync inputs
    logic hs_meta_ff, hs_sync_ff, hs_prev_ff;
    logic vs_meta_ff, vs_sync_ff, vs_prev_ff;

    // window counters
    logic [11:0] pix_cnt_ff, line_len_ff, row_cnt_ff, frame_len_ff;
    logic [8:0] xtal_cnt_ff;
    logic collect_ff, vtick_ff;

    // engine
    vpa_pkg::vpa_state_e state_ff, nxt_state;
    logic [6:0] step_cnt_ff, nxt_step_cnt;
    logic kind_phase_ff, nxt_kind_phase;
    logic phase_apply_ff, window_apply_ff;

    // write decode
    wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_hs = S_AXI_WVALID & S_AXI_WREADY;
    wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
    wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire lane0 = do_write & wstrb_ff[0];
    wire [7:0] wbyte = wdata_ff[7:0];
    wire [7:0] ar_idx = S_AXI_ARADDR[9:2];
    wire ar_hi_zero = (S_AXI_ARADDR[11:10] == 2'h0);

    function automatic logic idx_mapped(input logic [7:0] idx);
        idx_mapped = (idx >= vpa_pkg::IDX_LINE_START_LO &&
                      idx <= vpa_pkg::IDX_CMD_OPTIONS) ||
                     idx == vpa_pkg::IDX_IRQ_STATUS ||
                     idx == vpa_pkg::IDX_IRQ_MASK;
    endfunction : idx_mapped

    function automatic logic wr_hit(input logic [7:0] idx,
                                    input logic [7:0] want);
        wr_hit = (idx == want);
    endfunction : wr_hit

    wire wr_line_start = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_LINE_START_LO);
    wire wr_cnt_hi = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_LINE_COUNT_HI);
    wire wr_cnt_lo = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_LINE_COUNT_LO);
    wire wr_meas = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_MEASURE_CFG);
    wire wr_cmd = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_PHASE_CMD);
    wire wr_vmask = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_VLINE_MASK);
    wire wr_hm_after = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_PIX_MASK_AFTER);
    wire wr_hm_before = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_PIX_MASK_BEFORE);
    wire wr_opt = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_CMD_OPTIONS);
    wire wr_irq_clr = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_IRQ_STATUS);
    wire wr_irq_mask = lane0 & wr_hit(aw_idx_ff, vpa_pkg::IDX_IRQ_MASK);

    // engine control
    wire engine_clear = opt_ff[vpa_pkg::OPT_ENGINE_CLEAR];
    wire busy = (state_ff != vpa_pkg::ST_IDLE);
    wire [2:0] cmd_code = wbyte[2:0];
    wire cmd_phase = (cmd_code == vpa_pkg::CMD_APPLY_PHASE);
    wire cmd_window = (cmd_code == vpa_pkg::CMD_APPLY_WINDOW);
    // a command during busy or clear is dropped, not queued
    wire cmd_take = wr_cmd & ~busy & ~engine_clear;
    wire start_phase = cmd_take & cmd_phase;
    wire start_window = cmd_take & cmd_window;
    wire bad_cmd = cmd_take & ~cmd_phase & ~cmd_window;
    wire [6:0] step_last = opt_ff[vpa_pkg::OPT_STEP_SLOW] ?
        vpa_pkg::STEP_VSYNCS_SLOW - 7'h01 :
        vpa_pkg::STEP_VSYNCS_FAST - 7'h01;
    wire upd_on_vs = opt_ff[vpa_pkg::OPT_UPDATE_ON_VSYNC];
    wire hs_edge = hs_sync_ff & ~hs_prev_ff;
    wire vs_edge = vs_sync_ff & ~vs_prev_ff;
    wire step_end = (state_ff == vpa_pkg::ST_STEP) & vs_edge &
                    (step_cnt_ff == step_last);
    wire nxt_phase_apply = (step_end & ~upd_on_vs) |
        ((state_ff == vpa_pkg::ST_WAITV) & vs_edge & kind_phase_ff);
    wire nxt_window_apply = (state_ff == vpa_pkg::ST_WAITV) & vs_edge &
                            ~kind_phase_ff;
    wire engine_done = (state_ff == vpa_pkg::ST_DONE);

    // collection window
    wire [8:0] excl_after_px = {hmask_after_ff, 1'b0};
    wire [8:0] excl_before_px = {hmask_before_ff, 1'b0};
    wire [11:0] px_left = line_len_ff - pix_cnt_ff;
    wire h_excl_after = pix_cnt_ff < {3'h0, excl_after_px};
    wire h_excl_before = px_left <= {3'h0, excl_before_px};
    wire [3:0] v_before = lines_before(vmask_ff[2:0]);
    wire [5:0] v_after = lines_after(vmask_ff[6:4]);
    wire [11:0] rows_left = frame_len_ff - row_cnt_ff;
    wire v_excl_after = row_cnt_ff < {6'h00, v_after};
    wire v_excl_before = rows_left <= {8'h00, v_before};
    wire nxt_collect = busy & ~h_excl_after & ~h_excl_before &
                       ~v_excl_after & ~v_excl_before;
    // vertical unit tick: per line, or per 512 crystal clocks
    wire nxt_vtick = meas_cfg_ff[vpa_pkg::MC_VUNITS_BIT] ?
        (xtal_cnt_ff == vpa_pkg::XTAL_UNIT_LAST) : hs_edge;

    // read mux
    wire [7:0] rd_byte =
        (ar_idx == vpa_pkg::IDX_LINE_START_LO) ? line_start_ff :
        (ar_idx == vpa_pkg::IDX_LINE_COUNT_HI) ? {4'h0, line_cnt_hi_ff} :
        (ar_idx == vpa_pkg::IDX_LINE_COUNT_LO) ? line_cnt_lo_ff :
        (ar_idx == vpa_pkg::IDX_MEASURE_CFG) ? {6'h00, meas_cfg_ff} :
        (ar_idx == vpa_pkg::IDX_PHASE_STATUS) ? {busy, 7'h00} :
        (ar_idx == vpa_pkg::IDX_VLINE_MASK) ? {1'b0, vmask_ff} :
        (ar_idx == vpa_pkg::IDX_PIX_MASK_AFTER) ? hmask_after_ff :
        (ar_idx == vpa_pkg::IDX_PIX_MASK_BEFORE) ? hmask_before_ff :
        (ar_idx == vpa_pkg::IDX_CMD_OPTIONS) ? opt_ff :
        (ar_idx == vpa_pkg::IDX_IRQ_STATUS) ? {6'h00, irq_stat_ff} :
        (ar_idx == vpa_pkg::IDX_IRQ_MASK) ? {6'h00, irq_mask_ff} : 8'h00;
    wire ar_ok = ar_hi_zero & idx_mapped(ar_idx);
    // out-of-range high address bits already folded into index 0xff
    wire aw_ok = idx_mapped(aw_idx_ff);

    // bus handshakes
    assign S_AXI_AWREADY = ~aw_held_ff & ~bvalid_ff;
    assign S_AXI_WREADY = ~w_held_ff & ~bvalid_ff;
    assign S_AXI_ARREADY = ~rvalid_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign S_AXI_RDATA = rdata_ff;

    // outputs
    assign IRQ = |(irq_stat_ff & irq_mask_ff);
    assign PHASE_APPLY = phase_apply_ff;
    assign WINDOW_APPLY = window_apply_ff;
    assign SEARCH_WORST = opt_ff[vpa_pkg::OPT_SEARCH_WORST];
    assign CHAN_MEASURE_EN =
        ~opt_ff[vpa_pkg::OPT_RED_OFF:vpa_pkg::OPT_BLUE_OFF];
    assign COLLECT_EN = collect_ff;
    assign VERT_TICK = vtick_ff;
    assign LINECOUNT_TIMED = meas_cfg_ff[vpa_pkg::MC_LINECNT_BIT];
    assign LINE_START_LOW = line_start_ff;
    assign LINE_COUNT = {line_cnt_hi_ff, line_cnt_lo_ff};

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_idx_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_held_ff <= 1'b1;
                aw_idx_ff <= S_AXI_AWADDR[11:10] == 2'h0 ?
                             S_AXI_AWADDR[9:2] : 8'hff;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
            if (w_hs) begin
                w_held_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= vpa_pkg::AXI_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= vpa_pkg::AXI_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else begin
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= aw_ok ? vpa_pkg::AXI_OKAY : vpa_pkg::AXI_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
            if (ar_hs) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= ar_ok ? vpa_pkg::AXI_OKAY : vpa_pkg::AXI_SLVERR;
            end else if (S_AXI_RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            line_start_ff <= vpa_pkg::RST_LINE_START_LO;
            line_cnt_hi_ff <= vpa_pkg::RST_LINE_COUNT_HI;
            line_cnt_lo_ff <= vpa_pkg::RST_LINE_COUNT_LO;
            meas_cfg_ff <= vpa_pkg::RST_MEASURE_CFG;
            vmask_ff <= vpa_pkg::RST_VLINE_MASK;
            hmask_after_ff <= vpa_pkg::RST_PIX_MASK_AFTER;
            hmask_before_ff <= vpa_pkg::RST_PIX_MASK_BEFORE;
            opt_ff <= vpa_pkg::RST_CMD_OPTIONS;
            irq_mask_ff <= 2'h0;
        end else begin
            if (wr_line_start) line_start_ff <= wbyte;
            if (wr_cnt_hi) line_cnt_hi_ff <= wbyte[3:0];
            if (wr_cnt_lo) line_cnt_lo_ff <= wbyte;
            if (wr_meas) meas_cfg_ff <= wbyte[1:0];
            if (wr_vmask) vmask_ff <= {wbyte[6:4], 1'b0, wbyte[2:0]};
            if (wr_hm_after) hmask_after_ff <= wbyte;
            if (wr_hm_before) hmask_before_ff <= wbyte;
            // bit 7 kept at zero; host should write it as zero
            if (wr_opt) opt_ff <= {1'b0, wbyte[6:0]};
            if (wr_irq_mask) irq_mask_ff <= wbyte[1:0];
        end
    end

    // sticky events; a set in the clear cycle wins
    wire [1:0] irq_set = {bad_cmd, engine_done};
    wire [1:0] irq_clr = wr_irq_clr ? wbyte[1:0] : 2'h0;
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            irq_stat_ff <= 2'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    // two flops before any logic sees the sync pins
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            hs_meta_ff <= 1'b0;
            hs_sync_ff <= 1'b0;
            hs_prev_ff <= 1'b0;
            vs_meta_ff <= 1'b0;
            vs_sync_ff <= 1'b0;
            vs_prev_ff <= 1'b0;
        end else begin
            hs_meta_ff <= HSYNC_IN;
            hs_sync_ff <= hs_meta_ff;
            hs_prev_ff <= hs_sync_ff;
            vs_meta_ff <= VSYNC_IN;
            vs_sync_ff <= vs_meta_ff;
            vs_prev_ff <= vs_sync_ff;
        end
    end

    // line and frame lengths from the previous period
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            pix_cnt_ff <= 12'h000;
            line_len_ff <= 12'hfff;
            row_cnt_ff <= 12'h000;
            frame_len_ff <= 12'hfff;
            xtal_cnt_ff <= 9'h000;
        end else begin
            xtal_cnt_ff <= xtal_cnt_ff + 9'h001;
            if (hs_edge) begin
                line_len_ff <= pix_cnt_ff;
                pix_cnt_ff <= 12'h000;
            end else if (PIXEL_EN && pix_cnt_ff != 12'hfff) begin
                pix_cnt_ff <= pix_cnt_ff + 12'h001;
            end
            if (vs_edge) begin
                frame_len_ff <= row_cnt_ff;
                row_cnt_ff <= 12'h000;
            end else if (hs_edge && row_cnt_ff != 12'hfff) begin
                row_cnt_ff <= row_cnt_ff + 12'h001;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            collect_ff <= 1'b0;
            vtick_ff <= 1'b0;
        end else begin
            collect_ff <= nxt_collect;
            vtick_ff <= nxt_vtick;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_step_cnt = step_cnt_ff;
        nxt_kind_phase = kind_phase_ff;
        case (state_ff)
            vpa_pkg::ST_IDLE: begin
                nxt_step_cnt = 7'h00;
                if (start_phase) begin
                    nxt_state = vpa_pkg::ST_STEP;
                    nxt_kind_phase = 1'b1;
                end else if (start_window) begin
                    nxt_state = vpa_pkg::ST_WAITV;
                    nxt_kind_phase = 1'b0;
                end
            end
            vpa_pkg::ST_STEP: begin
                if (step_end) begin
                    nxt_state = upd_on_vs ? vpa_pkg::ST_WAITV :
                                vpa_pkg::ST_DONE;
                end else if (vs_edge) begin
                    nxt_step_cnt = step_cnt_ff + 7'h01;
                end
            end
            vpa_pkg::ST_WAITV: begin
                if (vs_edge) nxt_state = vpa_pkg::ST_DONE;
            end
            vpa_pkg::ST_DONE: nxt_state = vpa_pkg::ST_IDLE;
            default: nxt_state = vpa_pkg::ST_IDLE;
        endcase
    end

    // clear bit holds the engine and its pulses in reset
    always_ff @(posedge CLK_SYS) begin
        if (!NRST || engine_clear) begin
            state_ff <= vpa_pkg::ST_IDLE;
            step_cnt_ff <= 7'h00;
            kind_phase_ff <= 1'b0;
            phase_apply_ff <= 1'b0;
            window_apply_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            step_cnt_ff <= nxt_step_cnt;
            kind_phase_ff <= nxt_kind_phase;
            phase_apply_ff <= nxt_phase_apply;
            window_apply_ff <= nxt_window_apply;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    a_reset_values: assert property (disable iff (1'b0)
        !NRST |=> line_start_ff == 8'h26 && LINE_COUNT == 12'h400 &&
        opt_ff == 8'h20 && hmask_after_ff == 8'h01 && vmask_ff == 7'h01)
        else $error("register reset value wrong");
    a_cmd_launch: assert property (start_phase |=> busy &&
        state_ff == vpa_pkg::ST_STEP) else $error("phase cmd not launched");
    a_reserved_ignored: assert property (bad_cmd |=> !busy ##1
        irq_stat_ff[vpa_pkg::IRQ_BADCMD_BIT]) else $error("reserved ran");
    a_status_busy: assert property (ar_hs &&
        ar_idx == vpa_pkg::IDX_PHASE_STATUS |=> S_AXI_RDATA[7] == $past(busy))
        else $error("busy bit wrong");
    a_pix_after: assert property (h_excl_after |=> !COLLECT_EN)
        else $error("collect inside after-edge mask");
    a_pix_before: assert property (h_excl_before |=> !COLLECT_EN)
        else $error("collect inside before-edge mask");
    a_line_masks: assert property ((v_excl_before || v_excl_after)
        |=> !COLLECT_EN) else $error("collect inside line mask");
    a_line_tick: assert property (!meas_cfg_ff[0] && hs_edge
        |=> VERT_TICK) else $error("line tick missing");
    a_step_bound: assert property (state_ff == vpa_pkg::ST_STEP
        |-> step_cnt_ff <= step_last) else $error("step count overran");
    a_vsync_update: assert property (PHASE_APPLY &&
        $past(upd_on_vs) |-> $past(state_ff) == vpa_pkg::ST_WAITV &&
        $past(vs_edge)) else $error("phase applied off vsync");
    a_engine_clear: assert property (engine_clear |=> !busy &&
        !PHASE_APPLY) else $error("engine not held in reset");
    a_done_clears: assert property (engine_done |=> !busy)
        else $error("busy stuck after done");

    c_phase_done: cover property (start_phase ##[1:1000] PHASE_APPLY);
    c_window_done: cover property (start_window ##[1:1000] WINDOW_APPLY);
    c_bad_cmd: cover property (bad_cmd);
    c_irq: cover property (IRQ && irq_stat_ff[vpa_pkg::IRQ_DONE_BIT]);
endmodule : vpa_phase_adjust_regs
`default_nettype wire

// [sim/video_phase_adjust_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module video_phase_adjust_control_test;
    logic clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic hs = 0, vs = 0, awr, wr_, bv, arr, rv, irq, pa, wa, sw, ce, vt, lt;
    logic [11:0] awa = 12'h000, ara = 12'h000, lc;
    logic [31:0] wd = 32'h0, rd_;
    logic [3:0] ws = 4'h0;
    logic [1:0] brd, rrd;
    logic [2:0] cme;
    logic [7:0] lsl;
    int fail_count = 0, checks_done = 0, n_ph = 0, n_win = 0, n_vt = 0;
    int n_ce = 0;
    always #4 clk = ~clk;
    vpa_phase_adjust_regs i_dut (.CLK_SYS(clk), .NRST(nrst),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_), .S_AXI_BRESP(brd), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_), .S_AXI_RRESP(rrd),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .HSYNC_IN(hs),
        .VSYNC_IN(vs), .PIXEL_EN(1'b1), .IRQ(irq), .PHASE_APPLY(pa),
        .WINDOW_APPLY(wa), .SEARCH_WORST(sw), .CHAN_MEASURE_EN(cme),
        .COLLECT_EN(ce), .VERT_TICK(vt), .LINECOUNT_TIMED(lt),
        .LINE_START_LOW(lsl), .LINE_COUNT(lc));
    always @(posedge clk) begin
        if (pa === 1'b1) n_ph++;
        if (wa === 1'b1) n_win++;
        if (vt === 1'b1) n_vt++;
        if (ce === 1'b1) n_ce++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, d, input logic [1:0] er);
        @(posedge clk);
        awa <= {2'b00, i, 2'b00};
        wd <= {24'h0, d};
        ws <= 4'h1;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
        end while (bv !== 1'b1);
        chk({30'h0, brd}, {30'h0, er});
        br <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] i, e, input logic [1:0] er);
        @(posedge clk);
        ara <= {2'b00, i, 2'b00};
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        chk(rd_, {24'h0, e});
        chk({30'h0, rrd}, {30'h0, er});
        rr <= 1'b0;
    endtask : rchk
    // sync pins are asynchronous; wide pulses survive the 2-flop sync
    task automatic pulse(input bit v, input int n);
        repeat (n) begin
            @(posedge clk);
            vs <= v;
            hs <= !v;
            repeat (4) @(posedge clk);
            vs <= 1'b0;
            hs <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask : pulse
    task automatic t_regs;
        logic [23:0] t [8] = '{24'h4c5a5a, 24'h4dff0f, 24'h4e3434,
            24'h4f0303, 24'h527f77, 24'h530202, 24'h540303, 24'h550d0d};
        logic [15:0] r [11] = '{16'h4c26, 16'h4d04, 16'h4e00, 16'h4f00,
            16'h5000, 16'h5100, 16'h5201, 16'h5301, 16'h5401, 16'h5520,
            16'h5c00};
        foreach (r[k])
            rchk(r[k][15:8], r[k][7:0], 2'h0);
        chk({16'h0, lc, sw, cme}, 32'h4007);
        foreach (t[k]) begin
            wr(t[k][23:16], t[k][15:8], 2'h0);
            rchk(t[k][23:16], t[k][7:0], 2'h0);
        end
        chk({lsl, lc, 7'h0, lt, sw, cme}, 32'h5af3401a);
        wr(8'h60, 8'h11, 2'h2);
        rchk(8'h60, 8'h00, 2'h2);
        wr(8'h4f, 8'h00, 2'h0);
        // let a tick launched under the old unit setting drain first
        repeat (2) @(negedge clk);
        n_vt = 0;
        pulse(1'b0, 3);
        chk(n_vt, 3);
        wr(8'h4f, 8'h01, 2'h0);
        @(negedge clk);
        n_vt = 0;
        repeat (1024) @(negedge clk);
        chk(n_vt, 2);
    endtask : t_regs
    task automatic t_phase(input logic [7:0] opt, input int n);
        wr(8'h55, opt, 2'h0);
        wr(8'h5c, 8'h01, 2'h0);
        n_ph = 0;
        wr(8'h50, 8'hfb, 2'h0);
        rchk(8'h51, 8'h80, 2'h0);
        pulse(1'b1, n - 1);
        chk(n_ph, 0);
        pulse(1'b1, 1);
        chk({n_ph[15:0], 15'h0, irq}, 32'h10001);
        rchk(8'h51, 8'h00, 2'h0);
        wr(8'h5b, 8'h01, 2'h0);
        chk({31'h0, irq}, 0);
    endtask : t_phase
    task automatic t_other;
        wr(8'h50, 8'h01, 2'h0);
        rchk(8'h5b, 8'h02, 2'h0);
        chk({31'h0, irq}, 0);
        rchk(8'h51, 8'h00, 2'h0);
        n_ph = 0;
        n_win = 0;
        wr(8'h52, 8'h00, 2'h0);
        wr(8'h50, 8'h04, 2'h0);
        rchk(8'h51, 8'h80, 2'h0);
        // 13-cycle lines, masks 2 and 3: pixels 4,5 of rows 5..8 collect
        n_ce = 0;
        pulse(1'b0, 8);
        chk(n_ce, 8);
        pulse(1'b1, 1);
        chk({n_win[15:0], n_ph[15:0]}, 32'h10000);
        wr(8'h55, 8'h40, 2'h0);
        wr(8'h50, 8'h03, 2'h0);
        rchk(8'h51, 8'h00, 2'h0);
        wr(8'h55, 8'h00, 2'h0);
        wr(8'h50, 8'h03, 2'h0);
        rchk(8'h51, 8'h80, 2'h0);
        wr(8'h55, 8'h40, 2'h0);
        rchk(8'h51, 8'h00, 2'h0);
    endtask : t_other
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_phase(8'h00, 28);
        t_phase(8'h30, 65);
        t_other;
        test_done;
    end
    initial begin
        #400000;
        fail_count++;
        test_done;
    end
endmodule : video_phase_adjust_control_test
`default_nettype wire
